// ===== hdl/tx_cmd_parser.sv
// Device end: parses command words and strips buffer framing
`timescale 1ns/1ps
`include "tx_cmd_consts.svh"
module tx_cmd_parser
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  tx_cmd_if.device         bus,
  input  wire logic        tx_error_clear,
  output logic             tx_error_flag,
  output logic             tx_buffer_done_flag,
  output logic             fifo_wr,
  output logic [31:0]      fifo_data,
  output logic [1:0]       fifo_start_byte,
  output logic             fifo_first,
  output logic             fifo_last,
  output logic             status_tag_valid,
  output logic [15:0]      status_tag
);
  // Half-word assembly
  logic        half_have_reg;   // Lower half already held
  logic        half_have_next;
  logic [15:0] half_lo_reg;     // Held lower half
  logic [15:0] half_lo_next;
  logic        word_stb;        // Full word assembled this cycle
  logic [31:0] word;            // Assembled word

  // Parser state
  tx_cmd_pkg::parse_state_t state_reg;
  tx_cmd_pkg::parse_state_t state_next;
  logic [31:0] cmd_a_reg;       // Current command A
  logic [31:0] cmd_a_next;
  logic [31:0] cmd_b_reg;       // Command B of packet's first buffer
  logic [31:0] cmd_b_next;
  logic        b_seen_reg;      // A first segment has been taken
  logic        b_seen_next;
  tx_cmd_pkg::word_cnt_t idx_reg;    // Data word index in buffer
  tx_cmd_pkg::word_cnt_t idx_next;
  logic [11:0] len_sum_reg;     // Running sum of buffer sizes
  logic [11:0] len_sum_next;
  logic        err_reg;
  logic        err_next;
  logic        done_reg;
  logic        done_next;
  logic        fwr_reg;
  logic        fwr_next;
  logic [31:0] fdat_reg;
  logic [31:0] fdat_next;
  logic [1:0]  fsb_reg;
  logic [1:0]  fsb_next;
  logic        ffirst_reg;
  logic        ffirst_next;
  logic        flast_reg;
  logic        flast_next;
  logic        tagv_reg;
  logic        tagv_next;
  logic [15:0] tag_reg;
  logic [15:0] tag_next;

  // Decoded command A fields for the active buffer
  tx_cmd_pkg::word_cnt_t used_w;   // Words holding offset and payload
  tx_cmd_pkg::word_cnt_t total_w;  // Words written including padding
  tx_cmd_pkg::word_cnt_t skip_w;   // Whole words before the offset
  logic [11:0] sum_with_buf;       // Sum including this buffer

  // lower half first
  // The first write of a pair is the low half; the second completes it.
  always_comb
  begin
    half_have_next = half_have_reg;
    half_lo_next   = half_lo_reg;
    word_stb       = 1'b0;
    word           = {bus.wr_half, half_lo_reg};
    if (bus.wr_stb)
    begin
      if (half_have_reg)
      begin
        word_stb       = 1'b1;
        half_have_next = 1'b0;
      end
      else
      begin
        half_lo_next   = bus.wr_half;
        half_have_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      half_have_reg <= 1'b0;
      half_lo_reg   <= 16'h0000;
    end
    else
    begin
      half_have_reg <= half_have_next;
      half_lo_reg   <= half_lo_next;
    end
  end

  // Field decode of the held command A
  always_comb
  begin
    skip_w  = {8'h00, cmd_a_reg[`A_OFFS_HI:`A_OFFS_LO+2]};
    used_w  = tx_cmd_pkg::used_words(cmd_a_reg[`A_OFFS_HI:`A_OFFS_LO],
                                     cmd_a_reg[`A_SIZE_HI:`A_SIZE_LO]);
    total_w = tx_cmd_pkg::padded_words(used_w,
                                       cmd_a_reg[`A_ALIGN_HI:`A_ALIGN_LO]);
    sum_with_buf = len_sum_reg + {1'b0, cmd_a_reg[`A_SIZE_HI:`A_SIZE_LO]};
  end

  // Command sequencing, data filtering and checks
  // A buffer ends when its last padded word arrives; a buffer with zero offset
  // and zero size ends right after command B, since no data words follow it.
  always_comb
  begin
    state_next   = state_reg;
    cmd_a_next   = cmd_a_reg;
    cmd_b_next   = cmd_b_reg;
    b_seen_next  = b_seen_reg;
    idx_next     = idx_reg;
    len_sum_next = len_sum_reg;
    err_next     = err_reg;
    done_next    = 1'b0;
    fwr_next     = 1'b0;
    fdat_next    = fdat_reg;
    fsb_next     = fsb_reg;
    ffirst_next  = 1'b0;
    flast_next   = 1'b0;
    tagv_next    = 1'b0;
    tag_next     = tag_reg;
    // Software clear; any set below overrides it
    if (tx_error_clear)
      err_next = 1'b0;
    if (word_stb)
    begin
      case (state_reg)
        tx_cmd_pkg::PS_CMD_A:
        begin
          cmd_a_next = word;
          if (word[`A_ALIGN_HI:`A_ALIGN_LO] == `ALIGN_CODE_RV)
            err_next = 1'b1;
          state_next = tx_cmd_pkg::PS_CMD_B;
        end
        tx_cmd_pkg::PS_CMD_B:
        begin
          idx_next = '0;
          if (cmd_a_reg[`A_FIRST_BIT])
          begin
            cmd_b_next   = word;
            b_seen_next  = 1'b1;
            len_sum_next = 12'h000;
          end
          else if (!b_seen_reg || word != cmd_b_reg)
            err_next = 1'b1;
          if (total_w == '0)
          begin
            // Empty buffer: finish at once
            done_next  = cmd_a_reg[`A_IOC_BIT];
            state_next = tx_cmd_pkg::PS_CMD_A;
          end
          else
            state_next = tx_cmd_pkg::PS_DATA;
        end
        tx_cmd_pkg::PS_DATA:
        begin
          idx_next = idx_reg + 1'b1;
          if (idx_reg >= skip_w && idx_reg < used_w)
          begin
            fwr_next    = 1'b1;
            fdat_next   = word;
            ffirst_next = (idx_reg == skip_w);
            flast_next  = (idx_reg == used_w - 1'b1);
            fsb_next    = cmd_a_reg[`A_OFFS_LO+1:`A_OFFS_LO];
          end
          if (idx_reg == total_w - 1'b1)
          begin
            state_next = tx_cmd_pkg::PS_CMD_A;
            done_next  = cmd_a_reg[`A_IOC_BIT];
          end
        end
        default:
          state_next = tx_cmd_pkg::PS_CMD_A;
      endcase
    end
    // Packet accounting once the buffer's last word is in
    if (word_stb &&
        ((state_reg == tx_cmd_pkg::PS_DATA && idx_reg == total_w - 1'b1) ||
         (state_reg == tx_cmd_pkg::PS_CMD_B && total_w == '0)))
    begin
      len_sum_next = cmd_a_reg[`A_FIRST_BIT] ?
                     {1'b0, cmd_a_reg[`A_SIZE_HI:`A_SIZE_LO]} : sum_with_buf;
      if (cmd_a_reg[`A_LAST_BIT])
      begin
        if (len_sum_next != {1'b0, cmd_b_next[`B_LEN_HI:`B_LEN_LO]})
          err_next = 1'b1;
        tagv_next   = 1'b1;
        tag_next    = cmd_b_next[`B_TAG_HI:`B_TAG_LO];
        b_seen_next = 1'b0;
      end
    end
  end

  // Registers of the parser
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg   <= tx_cmd_pkg::PS_CMD_A;
      cmd_a_reg   <= 32'h00000000;
      cmd_b_reg   <= 32'h00000000;
      b_seen_reg  <= 1'b0;
      idx_reg     <= '0;
      len_sum_reg <= 12'h000;
      err_reg     <= 1'b0;
      done_reg    <= 1'b0;
      fwr_reg     <= 1'b0;
      fdat_reg    <= 32'h00000000;
      fsb_reg     <= 2'h0;
      ffirst_reg  <= 1'b0;
      flast_reg   <= 1'b0;
      tagv_reg    <= 1'b0;
      tag_reg     <= 16'h0000;
    end
    else
    begin
      state_reg   <= state_next;
      cmd_a_reg   <= cmd_a_next;
      cmd_b_reg   <= cmd_b_next;
      b_seen_reg  <= b_seen_next;
      idx_reg     <= idx_next;
      len_sum_reg <= len_sum_next;
      err_reg     <= err_next;
      done_reg    <= done_next;
      fwr_reg     <= fwr_next;
      fdat_reg    <= fdat_next;
      fsb_reg     <= fsb_next;
      ffirst_reg  <= ffirst_next;
      flast_reg   <= flast_next;
      tagv_reg    <= tagv_next;
      tag_reg     <= tag_next;
    end
  end

  // All outputs straight from flip-flops
  assign tx_error_flag       = err_reg;
  assign tx_buffer_done_flag = done_reg;
  assign fifo_wr             = fwr_reg;
  assign fifo_data           = fdat_reg;
  assign fifo_start_byte     = fsb_reg;
  assign fifo_first          = ffirst_reg;
  assign fifo_last           = flast_reg;
  assign status_tag_valid    = tagv_reg;
  assign status_tag          = tag_reg;
endmodule

// ===== hdl/tx_cmd_consts.svh
// Constants for the transmit command parser and its host writer
`ifndef TX_CMD_CONSTS_SVH
`define TX_CMD_CONSTS_SVH
`define A_IOC_BIT     31
`define A_RSVD_HI     30
`define A_RSVD_LO     26
`define A_ALIGN_HI    25
`define A_ALIGN_LO    24
`define A_OFFS_HI     20
`define A_OFFS_LO     16
`define A_FIRST_BIT   13
`define A_LAST_BIT    12
`define A_SIZE_HI     10
`define A_SIZE_LO     0
`define B_TAG_HI      31
`define B_TAG_LO      16
`define B_LEN_HI      10
`define B_LEN_LO      0
`define ALIGN_CODE_4  2'h0
`define ALIGN_CODE_16 2'h1
`define ALIGN_CODE_32 2'h2
`define ALIGN_CODE_RV 2'h3
`define ALIGN_MASK_4  11'h000
`define ALIGN_MASK_16 11'h003
`define ALIGN_MASK_32 11'h007
`define WORD_CNT_W    11
`endif

// ===== hdl/tx_cmd_pkg.sv
// Types and shared decode for the transmit command path
`include "tx_cmd_consts.svh"
package tx_cmd_pkg;
  // Parser states
  typedef enum logic [1:0]
  {
    PS_CMD_A = 2'b00,
    PS_CMD_B = 2'b01,
    PS_DATA  = 2'b10
  } parse_state_t;
  // Host writer states
  typedef enum logic [2:0]
  {
    HS_IDLE = 3'b000,
    HS_CMD_A = 3'b001,
    HS_CMD_B = 3'b010,
    HS_DATA = 3'b011,
    HS_PAD  = 3'b100
  } host_state_t;
  typedef logic [`WORD_CNT_W-1:0] word_cnt_t;

  // Words written for a buffer once rounded up to its alignment
  function automatic word_cnt_t padded_words(input word_cnt_t words,
                                             input logic [1:0] code);
    word_cnt_t mask;
    mask = `ALIGN_MASK_4;
    if (code == `ALIGN_CODE_16)
      mask = `ALIGN_MASK_16;
    else if (code == `ALIGN_CODE_32)
      mask = `ALIGN_MASK_32;
    padded_words = (words + mask) & ~mask;
  endfunction

  // Words that hold offset plus payload bytes
  function automatic word_cnt_t used_words(input logic [4:0] offs,
                                           input logic [10:0] size);
    logic [11:0] bytes;
    bytes = {7'h00, offs} + {1'b0, size} + 12'h003;
    // Word count never needs the top bit; widen on purpose
    used_words = {1'b0, bytes[11:2]};
  endfunction
endpackage

// ===== hdl/tx_cmd_if.sv
// Sixteen-bit host write port between host writer and parser
`timescale 1ns/1ps
interface tx_cmd_if;
  logic        wr_stb;   // One 16-bit write this cycle
  logic [15:0] wr_half;  // Write data half word

  modport host
  (
    output wr_stb,
    output wr_half
  );
  modport device
  (
    input wr_stb,
    input wr_half
  );
endinterface

// ===== hdl/tx_cmd_host.sv
// Host end: writes command words, payload and padding as half words
`timescale 1ns/1ps
`include "tx_cmd_consts.svh"
module tx_cmd_host
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  tx_cmd_if.host           bus,
  input  wire logic        buf_start,
  output logic             buf_busy,
  input  wire logic        buf_ioc,
  input  wire logic [1:0]  buf_align,
  input  wire logic [4:0]  buf_offset,
  input  wire logic [10:0] buf_size,
  input  wire logic        buf_first,
  input  wire logic        buf_last,
  input  wire logic [15:0] pkt_tag,
  input  wire logic [10:0] pkt_len,
  input  wire logic        usr_valid,
  input  wire logic [31:0] usr_word,
  output logic             usr_ready
);
  tx_cmd_pkg::host_state_t state_reg;
  tx_cmd_pkg::host_state_t state_next;
  logic [31:0] cmd_a_reg;     // Latched command A
  logic [31:0] cmd_a_next;
  logic [31:0] cmd_b_reg;     // Latched command B
  logic [31:0] cmd_b_next;
  logic [31:0] word_reg;      // Word being sent
  logic [31:0] word_next;
  logic        hi_reg;        // Upper half goes next
  logic        hi_next;
  logic        stb_reg;
  logic        stb_next;
  logic [15:0] half_reg;
  logic [15:0] half_next;
  tx_cmd_pkg::word_cnt_t cnt_reg;   // Words left in this phase
  tx_cmd_pkg::word_cnt_t cnt_next;
  tx_cmd_pkg::word_cnt_t pad_reg;   // Padding words still owed
  tx_cmd_pkg::word_cnt_t pad_next;
  tx_cmd_pkg::word_cnt_t used_w;
  logic        word_free;     // No word in flight this cycle

  assign used_w = tx_cmd_pkg::used_words(cmd_a_reg[`A_OFFS_HI:`A_OFFS_LO],
                                         cmd_a_reg[`A_SIZE_HI:`A_SIZE_LO]);
  assign word_free = !hi_reg;
  // User words are only taken between word transfers and while owed;
  // without the count term a word would look taken as data ends
  assign usr_ready = (state_reg == tx_cmd_pkg::HS_DATA) && word_free &&
                     (cnt_reg != '0);
  assign buf_busy  = (state_reg != tx_cmd_pkg::HS_IDLE);

  // Sequencer: each word costs two cycles, low half first
  always_comb
  begin
    state_next = state_reg;
    cmd_a_next = cmd_a_reg;
    cmd_b_next = cmd_b_reg;
    word_next  = word_reg;
    hi_next    = 1'b0;
    stb_next   = 1'b0;
    half_next  = half_reg;
    cnt_next   = cnt_reg;
    pad_next   = pad_reg;
    if (hi_reg)
    begin
      stb_next  = 1'b1;
      half_next = word_reg[31:16];
    end
    else
    begin
      case (state_reg)
        tx_cmd_pkg::HS_IDLE:
          if (buf_start)
          begin
            cmd_a_next = {buf_ioc, 5'h00, buf_align, 3'h0, buf_offset,
                          2'h0, buf_first, buf_last, 1'b0, buf_size};
            cmd_b_next = {pkt_tag, 5'h00, pkt_len};
            state_next = tx_cmd_pkg::HS_CMD_A;
          end
        tx_cmd_pkg::HS_CMD_A:
        begin
          word_next  = cmd_a_reg;
          state_next = tx_cmd_pkg::HS_CMD_B;
        end
        tx_cmd_pkg::HS_CMD_B:
        begin
          word_next = cmd_b_reg;
          cnt_next  = used_w;
          pad_next  = tx_cmd_pkg::padded_words(used_w,
                      cmd_a_reg[`A_ALIGN_HI:`A_ALIGN_LO]) - used_w;
          state_next = tx_cmd_pkg::HS_DATA;
        end
        tx_cmd_pkg::HS_DATA:
          if (cnt_reg == '0)
            state_next = tx_cmd_pkg::HS_PAD;
          else if (usr_valid)
          begin
            word_next = usr_word;
            cnt_next  = cnt_reg - 1'b1;
          end
        tx_cmd_pkg::HS_PAD:
          if (pad_reg == '0)
            state_next = tx_cmd_pkg::HS_IDLE;
          else
          begin
            word_next = 32'h00000000;
            pad_next  = pad_reg - 1'b1;
          end
        default:
          state_next = tx_cmd_pkg::HS_IDLE;
      endcase
      if (state_reg == tx_cmd_pkg::HS_CMD_A ||
          state_reg == tx_cmd_pkg::HS_CMD_B ||
          (state_reg == tx_cmd_pkg::HS_DATA && cnt_reg != '0 && usr_valid) ||
          (state_reg == tx_cmd_pkg::HS_PAD && pad_reg != '0))
      begin
        stb_next  = 1'b1;
        half_next = word_next[15:0];
        hi_next   = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= tx_cmd_pkg::HS_IDLE;
      cmd_a_reg <= 32'h00000000;
      cmd_b_reg <= 32'h00000000;
      word_reg  <= 32'h00000000;
      hi_reg    <= 1'b0;
      stb_reg   <= 1'b0;
      half_reg  <= 16'h0000;
      cnt_reg   <= '0;
      pad_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cmd_a_reg <= cmd_a_next;
      cmd_b_reg <= cmd_b_next;
      word_reg  <= word_next;
      hi_reg    <= hi_next;
      stb_reg   <= stb_next;
      half_reg  <= half_next;
      cnt_reg   <= cnt_next;
      pad_reg   <= pad_next;
    end
  end

  assign bus.wr_stb  = stb_reg;
  assign bus.wr_half = half_reg;
endmodule

// ===== test/tx_cmd_assertions.sv
// Checker for the half-word write port and the parser outputs
`timescale 1ns/1ps
module tx_cmd_assertions
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        wr_stb,
  input wire logic [15:0] wr_half,
  input wire logic        tx_error_clear,
  input wire logic        tx_error_flag,
  input wire logic        tx_buffer_done_flag,
  input wire logic        fifo_wr,
  input wire logic [31:0] fifo_data,
  input wire logic        fifo_first,
  input wire logic        fifo_last,
  input wire logic        status_tag_valid,
  input wire logic [15:0] status_tag
);
  logic        half_odd_reg;  // Low half taken, high half due
  logic        half_odd_next;
  logic [15:0] lo_half_reg;   // Low half kept for its partner
  logic [15:0] lo_half_next;

  // Pair tracking; a lone half leaves the phase flipped on purpose
  always_comb
  begin
    half_odd_next = half_odd_reg;
    lo_half_next  = lo_half_reg;
    if (wr_stb)
    begin
      half_odd_next = !half_odd_reg;
      if (!half_odd_reg)
        lo_half_next = wr_half;
    end
  end

  // Register the tracker
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      half_odd_reg <= 1'b0;
      lo_half_reg  <= 16'h0000;
    end
    else
    begin
      half_odd_reg <= half_odd_next;
      lo_half_reg  <= lo_half_next;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Completing high half of a pair
  sequence hi_half_s;
    wr_stb && half_odd_reg;
  endsequence
  // A word leaves for the FIFO
  sequence word_out_s;
    fifo_wr;
  endsequence

  pair_store_a: assert property (
    word_out_s |-> $past(wr_stb && half_odd_reg))
    else $error("Stored word without a completed pair");
  low_half_a: assert property (
    hi_half_s ##1 word_out_s |-> fifo_data == {$past(wr_half),
    $past(lo_half_reg)}) else $error("Stored word halves misordered");
  first_store_a: assert property (fifo_first |-> fifo_wr)
    else $error("First marker without a stored word");
  last_store_a: assert property (fifo_last |-> fifo_wr)
    else $error("Last marker without a stored word");
  done_pulse_a: assert property (
    tx_buffer_done_flag |=> !tx_buffer_done_flag)
    else $error("Done flag longer than one cycle");
  done_cause_a: assert property (
    tx_buffer_done_flag |-> $past(wr_stb && half_odd_reg))
    else $error("Done flag not after a completed word");
  tag_hold_a: assert property (
    status_tag_valid |=> $stable(status_tag))
    else $error("Status tag moved after report");
  tag_cause_a: assert property (
    status_tag_valid |-> $past(wr_stb && half_odd_reg))
    else $error("Tag report not after a completed word");
  err_sticky_a: assert property (
    tx_error_flag && !tx_error_clear |=> tx_error_flag)
    else $error("Error flag dropped without clear");
  err_cause_a: assert property (
    $rose(tx_error_flag) |-> $past(wr_stb && half_odd_reg))
    else $error("Error flag rose without a completed word");
endmodule

// ===== test/tb.sv
// Bench: host writer joined to parser, plus a hand-driven rogue writer
`timescale 1ns/1ps
`define CHECK(g, e) check_val(32'(g), 32'(e))
module tb;
  logic        sys_clk;         // 40 MHz clock
  logic        sys_rst;         // Sync reset, high
  logic        tx_error_clear;  // Error clear pulse
  logic        tx_error_flag;
  logic        tx_buffer_done_flag;
  logic        fifo_wr;
  logic [31:0] fifo_data;
  logic [1:0]  fifo_start_byte;
  logic        fifo_first;
  logic        fifo_last;
  logic        status_tag_valid;
  logic [15:0] status_tag;
  logic        buf_start;       // Descriptor strobe
  logic        buf_busy;
  logic        buf_ioc;
  logic [1:0]  buf_align;
  logic [4:0]  buf_offset;
  logic [10:0] buf_size;
  logic        buf_first;
  logic        buf_last;
  logic [15:0] pkt_tag;
  logic [10:0] pkt_len;
  logic        usr_valid;
  logic [31:0] usr_word;
  logic        usr_ready;
  logic        err2;            // Error flag of the rogue-fed parser
  logic        clr2;            // Its clear
  logic [31:0] store_q[$];      // Words seen on the FIFO side
  int          n_first;
  int          n_last;
  int          n_done;
  int          n_tag;
  logic [1:0]  last_start;
  int          bad_count;
  int          n_tests;
  tx_cmd_if    bus_if ();
  tx_cmd_if    rogue_if ();     // Driven by hand to break host rules

  tx_cmd_host i_tx_cmd_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(bus_if), .buf_start(buf_start), .buf_busy(buf_busy),
    .buf_ioc(buf_ioc), .buf_align(buf_align), .buf_offset(buf_offset),
    .buf_size(buf_size), .buf_first(buf_first), .buf_last(buf_last),
    .pkt_tag(pkt_tag), .pkt_len(pkt_len), .usr_valid(usr_valid),
    .usr_word(usr_word), .usr_ready(usr_ready));
  tx_cmd_parser i_tx_cmd_parser (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(bus_if), .tx_error_clear(tx_error_clear),
    .tx_error_flag(tx_error_flag),
    .tx_buffer_done_flag(tx_buffer_done_flag), .fifo_wr(fifo_wr),
    .fifo_data(fifo_data), .fifo_start_byte(fifo_start_byte),
    .fifo_first(fifo_first), .fifo_last(fifo_last),
    .status_tag_valid(status_tag_valid), .status_tag(status_tag));
  // Second parser sees only what the rogue writer sends
  tx_cmd_parser i_tx_cmd_parser_2 (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(rogue_if), .tx_error_clear(clr2), .tx_error_flag(err2),
    .tx_buffer_done_flag(), .fifo_wr(), .fifo_data(),
    .fifo_start_byte(), .fifo_first(), .fifo_last(),
    .status_tag_valid(), .status_tag());
  tx_cmd_assertions i_tx_cmd_assertions (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .wr_stb(bus_if.wr_stb), .wr_half(bus_if.wr_half),
    .tx_error_clear(tx_error_clear), .tx_error_flag(tx_error_flag),
    .tx_buffer_done_flag(tx_buffer_done_flag), .fifo_wr(fifo_wr),
    .fifo_data(fifo_data), .fifo_first(fifo_first),
    .fifo_last(fifo_last), .status_tag_valid(status_tag_valid),
    .status_tag(status_tag));

  // Clock source
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Record every FIFO-side event for the scenario checks
  always @(posedge sys_clk)
  begin
    if (fifo_wr === 1'b1)
    begin
      store_q.push_back(fifo_data);
      last_start = fifo_start_byte;
    end
    n_first += (fifo_first === 1'b1);
    n_last  += (fifo_last === 1'b1);
    n_done  += (tx_buffer_done_flag === 1'b1);
    n_tag   += (status_tag_valid === 1'b1);
  end

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One buffer through the host writer, judged at the FIFO side
  task automatic run_buf(input int ioc, align, offs, size, first, last,
                         input int tag, len, exp_err);
    int used;
    int idx;
    int k;
    logic rdy;
    used = (offs + size + 3) / 4;
    idx  = 0;
    store_q.delete();
    {n_first, n_last, n_done, n_tag} = '0;
    @(negedge sys_clk);
    {buf_ioc, buf_first, buf_last} = {ioc[0], first[0], last[0]};
    {buf_align, buf_offset, buf_size} = {align[1:0], offs[4:0], size[10:0]};
    {pkt_tag, pkt_len} = {tag[15:0], len[10:0]};
    buf_start = 1'b1;
    @(negedge sys_clk);
    buf_start = 1'b0;
    usr_valid = 1'b1;
    // Offer one word at a time; the host takes it when ready
    for (k = 0; k < 400 && idx < used; k++)
    begin
      usr_word = 32'hA0000000 | idx;
      #1;
      rdy = usr_ready;
      @(negedge sys_clk);
      if (rdy === 1'b1)
        idx++;
    end
    usr_valid = 1'b0;
    usr_word  = 32'h5A5A5A5A;
    for (k = 0; k < 400 && buf_busy !== 1'b0; k++)
      @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    `CHECK(store_q.size(), used - offs / 4);
    for (k = 0; k < store_q.size(); k++)
      `CHECK(store_q[k], 32'hA0000000 | (offs / 4 + k));
    `CHECK(last_start, offs % 4);
    `CHECK(n_first, 1);
    `CHECK(n_last, 1);
    `CHECK(n_done, ioc);
    `CHECK(n_tag, last);
    if (last != 0)
      `CHECK(status_tag, tag);
    `CHECK(tx_error_flag, exp_err);
  endtask

  // Rogue writer: one word as two halves, low first, then idle
  task automatic put_word(input logic [31:0] w);
    @(negedge sys_clk);
    rogue_if.wr_stb  = 1'b1;
    rogue_if.wr_half = w[15:0];
    @(negedge sys_clk);
    rogue_if.wr_half = w[31:16];
    @(negedge sys_clk);
    rogue_if.wr_stb  = 1'b0;
    rogue_if.wr_half = ~w[31:16];
  endtask

  // Single buffer, 16-byte end, offset 5, done flag asked for
  task automatic sc_single;
    run_buf(1, 1, 5, 13, 1, 1, 16'h00C1, 13, 0);
  endtask

  // Two-buffer packet, 32-byte end, lengths add up
  task automatic sc_two_buf;
    run_buf(0, 2, 0, 6, 1, 0, 16'h0B0B, 10, 0);
    run_buf(0, 2, 2, 4, 0, 1, 16'h0B0B, 10, 0);
  endtask

  // Length field disagrees with the buffer sizes; then clear
  task automatic sc_len_bad;
    run_buf(0, 0, 0, 8, 1, 1, 16'h0033, 9, 1);
    tx_error_clear = 1'b1;
    @(negedge sys_clk);
    tx_error_clear = 1'b0;
    @(negedge sys_clk);
    `CHECK(tx_error_flag, 0);
  endtask

  // Second command word changes inside one packet
  task automatic sc_cmd_b_bad;
    put_word(32'h00002004);
    put_word(32'h00010008);
    put_word(32'h11111111);
    repeat (2) @(negedge sys_clk);
    `CHECK(err2, 0);
    put_word(32'h00001004);
    put_word(32'h00020008);
    put_word(32'h22222222);
    repeat (2) @(negedge sys_clk);
    `CHECK(err2, 1);
    clr2 = 1'b1;
    @(negedge sys_clk);
    clr2 = 1'b0;
    @(negedge sys_clk);
    `CHECK(err2, 0);
  endtask

  // Reserved end alignment code in the first command word
  task automatic sc_align_rsvd;
    put_word(32'h03003004);
    repeat (2) @(negedge sys_clk);
    `CHECK(err2, 1);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Cut a hang short; the scenarios need well under 2000 cycles
  initial
  begin
    #(25 * 20000);
    bad_count++;
    final_report();
  end

  // Main sequence
  initial
  begin
    {sys_rst, tx_error_clear, clr2, buf_start, usr_valid} = 5'b10000;
    {buf_ioc, buf_first, buf_last, buf_align} = '0;
    {buf_offset, buf_size, pkt_tag, pkt_len} = '0;
    usr_word = 32'h00000000;
    rogue_if.wr_stb  = 1'b0;
    rogue_if.wr_half = 16'h0000;
    {bad_count, n_tests, n_first, n_last, n_done, n_tag} = '0;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    sc_single();
    sc_two_buf();
    sc_len_bad();
    sc_cmd_b_bad();
    sc_align_rsvd();
    final_report();
  end
endmodule
